/* File: ballast_mode_sequencer.sv */
/*
 Mode sequencer and gate-drive control of a dimming ballast controller.
 Analog thresholds arrive as comparator levels; current sources and
 switches on the analog nodes leave as enable levels.
 Assumes comparator outputs are asynchronous and are synchronised here;
 the oscillator frequency is modelled by halfPeriodEnd pulses.
*/
`timescale 1ns/100ps
module ballast_mode_sequencer
   import bms_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic supplyAboveRise,
   input  wire logic supplyBelowFall,
   input  wire logic lineAboveOn,
   input  wire logic lineBelowOff,
   input  wire logic shutdownInput,
   input  wire logic overTemp,
   input  wire logic timerAbove5v,
   input  wire logic oscBelowMin,
   input  wire logic csAboveWarmupRef,
   input  wire logic csAboveLimit,
   input  wire logic zeroCross,
   input  wire logic floorAboveRamp,
   input  wire logic halfPeriodEnd,
   output logic      highSideDrive,
   output logic      lowSideDrive,
   output logic      oscForceHigh,
   output logic      timerShortGnd,
   output logic      timerCharge1u,
   output logic      oscDischarge1u,
   output logic      oscCharge60u,
   output logic      oscDischarge15u,
   output logic      feedbackCharge,
   output logic      brightToTimer,
   output logic      useFixedLimitRef,
   output logic      refPhase,
   output logic      faultLatched,
   output logic [2:0] modeState
);
   // ******************************
   // Input synchronisers
   // ******************************
   localparam int NIN = 13;
   logic [NIN-1:0] rawIn;
   logic [NIN-1:0] syncIn;

   assign rawIn = {supplyAboveRise, supplyBelowFall, lineAboveOn,
                   lineBelowOff, shutdownInput, overTemp, timerAbove5v,
                   oscBelowMin, csAboveWarmupRef, csAboveLimit, zeroCross,
                   floorAboveRamp, halfPeriodEnd};

   bms_sync #(.W(NIN)) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .din   (rawIn),
      .dout  (syncIn)
   );

   logic sSupOk;
   logic sSupLow;
   logic sLineOn;
   logic sLineOff;
   logic sShut;
   logic sHot;
   logic sTimer5;
   logic sOscMin;
   logic sCsWarm;
   logic sCsLim;
   logic sZero;
   logic sFloor;
   logic sHalf;

   assign {sSupOk, sSupLow, sLineOn, sLineOff, sShut, sHot, sTimer5,
           sOscMin, sCsWarm, sCsLim, sZero, sFloor, sHalf} = syncIn;

   // ******************************
   // Mode decoding
   // ******************************
   // Modes in which the half-bridge switches
   function automatic logic isSwitching(input bms_mode_t m);
      return (m == BMS_WARM) || (m == BMS_IGNITE) || (m == BMS_DIM);
   endfunction

   // Modes that park the oscillator high and ground the timer
   function automatic logic isParked(input bms_mode_t m);
      return (m == BMS_LOCKOUT) || (m == BMS_FAULT);
   endfunction

   // Modes that limit current against the fixed reference
   function automatic logic usesFixedRef(input bms_mode_t m);
      return (m == BMS_IGNITE) || (m == BMS_DIM);
   endfunction

   // ******************************
   // Shutdown toggle detection
   // ******************************
   logic shutPrev;
   logic shutEdge;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         shutPrev <= 1'b0;
      end else begin
         shutPrev <= sShut;
      end
   end

   // A falling edge of shutdown completes a cycle of the pin
   assign shutEdge = shutPrev && !sShut;

   // ******************************
   // Mode sequencer
   // ******************************
   bms_mode_t mode;
   bms_mode_t next_mode;
   logic      hotLatch;
   logic      clearLatch;

   assign clearLatch = sSupLow || shutEdge;

   always_comb begin
      next_mode = mode;
      unique case (mode)
         BMS_LOCKOUT: begin
            if (sSupOk && sLineOn && !sShut && !hotLatch) begin
               next_mode = BMS_WARM;
            end
         end
         BMS_WARM: begin
            if (sTimer5) begin
               next_mode = BMS_IGNITE;
            end
         end
         BMS_IGNITE: begin
            if (sCsLim) begin
               next_mode = BMS_FAULT;
            end else if (sOscMin) begin
               next_mode = BMS_DIM;
            end
         end
         BMS_DIM: begin
            if (sCsLim) begin
               next_mode = BMS_FAULT;
            end
         end
         BMS_FAULT: begin
            if (clearLatch) begin
               next_mode = BMS_LOCKOUT;
            end
         end
         default: next_mode = BMS_LOCKOUT;
      endcase
      // Supply, shutdown, brown-out and heat override every mode except fault
      if (mode != BMS_FAULT) begin
         if (sHot) begin
            next_mode = BMS_FAULT;
         end else if (sSupLow || sShut || sLineOff) begin
            next_mode = BMS_LOCKOUT;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mode <= BMS_LOCKOUT;
      end else begin
         mode <= next_mode;
      end
   end

   // Heat event wins over a clear in the same cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hotLatch <= 1'b0;
      end else if (sHot) begin
         hotLatch <= 1'b1;
      end else if (clearLatch) begin
         hotLatch <= 1'b0;
      end
   end

   // ******************************
   // Half-bridge drive
   // ******************************
   logic bridgeEn;
   logic lowOn;
   logic highOn;
   logic lowRise;

   assign bridgeEn = isSwitching(next_mode);

   // Bridge restarts in dead time before the low side
   bms_bridge u_bridge (
      .clk     (clk),
      .rst_n   (rst_n),
      .enable  (bridgeEn),
      .halfEnd (sHalf),
      .lowOn   (lowOn),
      .highOn  (highOn),
      .lowRise (lowRise)
   );

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         highSideDrive <= 1'b0;
         lowSideDrive  <= 1'b0;
      end else begin
         highSideDrive <= highOn && bridgeEn;
         lowSideDrive  <= lowOn && bridgeEn;
      end
   end

   // ******************************
   // Zero-crossing blanking
   // ******************************
   // Window opens one cycle before the pin rises and the comparator
   // arrives two synchroniser cycles late, so the load is stretched
   localparam int               BLANK_LAG  = 3;
   localparam logic [CNT_W-1:0] BLANK_LOAD = BLANK_CNT
                                             + CNT_W'(BLANK_LAG);

   logic [CNT_W-1:0] blankCount;
   logic             zeroPrev;
   logic             zeroEdge;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         blankCount <= '0;
      end else if (lowRise) begin
         blankCount <= BLANK_LOAD;
      end else if (blankCount != '0) begin
         blankCount <= blankCount - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         zeroPrev <= 1'b0;
      end else begin
         zeroPrev <= sZero;
      end
   end

   // Edges inside the blank window are dropped, not delayed
   assign zeroEdge = sZero && !zeroPrev && (blankCount == '0);

   // ******************************
   // Phase detection
   // ******************************
   // Error pulse: load current crosses zero after the reference edge
   logic refPrev;
   logic refArmed;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         refPrev  <= 1'b0;
         refArmed <= 1'b0;
      end else begin
         refPrev <= sFloor;
         if (sFloor && !refPrev) begin
            refArmed <= 1'b1;
         end else if (zeroEdge || lowRise) begin
            refArmed <= 1'b0;
         end
      end
   end

   // ******************************
   // Analog node controls
   // ******************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         oscForceHigh     <= 1'b1;
         timerShortGnd    <= 1'b1;
         timerCharge1u    <= 1'b0;
         oscDischarge1u   <= 1'b0;
         oscCharge60u     <= 1'b0;
         oscDischarge15u  <= 1'b0;
         feedbackCharge   <= 1'b0;
         brightToTimer    <= 1'b0;
         useFixedLimitRef <= 1'b0;
         refPhase         <= 1'b0;
      end else begin
         oscForceHigh  <= isParked(next_mode);
         timerShortGnd <= isParked(next_mode);
         timerCharge1u <= (next_mode == BMS_WARM);
         oscDischarge1u <= (next_mode == BMS_WARM)
                           || (next_mode == BMS_IGNITE);
         oscCharge60u  <= (next_mode == BMS_WARM) && sCsWarm;
         oscDischarge15u <= (next_mode == BMS_DIM);
         feedbackCharge <= (next_mode == BMS_DIM) && refArmed
                           && zeroEdge;
         brightToTimer <= (next_mode == BMS_DIM);
         useFixedLimitRef <= usesFixedRef(next_mode);
         // Digital compare, so it holds at any frequency
         refPhase <= sFloor && (next_mode == BMS_DIM);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         faultLatched <= 1'b0;
         modeState    <= 3'h0;
      end else begin
         faultLatched <= (next_mode == BMS_FAULT);
         modeState    <= 3'(next_mode);
      end
   end
endmodule // ballast_mode_sequencer

/* File: bms_pkg.sv */
/*
 Package for the ballast mode sequencer: mode enumeration and timing
 counts derived from the 250 MHz system clock.
 Assumes a single clock domain; no registers reachable by software.
*/
package bms_pkg;
   // ******************************
   // Clock and timing
   // ******************************
   localparam int CLK_MHZ          = 250;
   localparam int DEAD_TIME_NS     = 2000;
   localparam int BLANK_TIME_NS    = 400;
   // Least times round up
   localparam int DEAD_CYC  = (DEAD_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int BLANK_CYC = (BLANK_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W     = 16;
   localparam logic [CNT_W-1:0] DEAD_CNT  = CNT_W'(DEAD_CYC);
   localparam logic [CNT_W-1:0] BLANK_CNT = CNT_W'(BLANK_CYC);

   // ******************************
   // Modes
   // ******************************
   typedef enum logic [2:0] {
      BMS_LOCKOUT,
      BMS_WARM,
      BMS_IGNITE,
      BMS_DIM,
      BMS_FAULT
   } bms_mode_t;

   // Half-bridge phases of one switching period
   typedef enum logic [1:0] {
      PH_LOW,
      PH_DEAD_A,
      PH_HIGH,
      PH_DEAD_B
   } bms_phase_t;
endpackage

/* File: bms_sync.sv */
/*
 Two flip-flop synchroniser for a vector of asynchronous comparator levels.
 Assumes the levels are quasi-static compared with the 4 ns clock.
*/
`timescale 1ns/100ps
module bms_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] stage1;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stage1 <= '0;
         dout   <= '0;
      end else begin
         stage1 <= din;
         dout   <= stage1;
      end
   end
endmodule // bms_sync

/* File: bms_bridge.sv */
/*
 Complementary half-bridge pulse generator with dead time.
 Each half period ends on a pulse of halfEnd from the oscillator model.
 Always starts on the low side after enable rises.
 Assumes halfEnd pulses are longer apart than the dead time.
*/
`timescale 1ns/100ps
module bms_bridge
   import bms_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic enable,
   input  wire logic halfEnd,
   output logic      lowOn,
   output logic      highOn,
   output logic      lowRise
);
   bms_phase_t       phase;
   logic [CNT_W-1:0] deadCount;

   // ******************************
   // Phase sequencing
   // ******************************
   always_ff @(posedge clk) begin
      if (!rst_n || !enable) begin
         phase     <= PH_DEAD_B;
         deadCount <= '0;
      end else begin
         unique case (phase)
            PH_LOW: if (halfEnd) begin
               phase     <= PH_DEAD_A;
               deadCount <= '0;
            end
            PH_HIGH: if (halfEnd) begin
               phase     <= PH_DEAD_B;
               deadCount <= '0;
            end
            PH_DEAD_A: if (deadCount == DEAD_CNT - 1'b1) begin
               phase <= PH_HIGH;
            end else begin
               deadCount <= deadCount + 1'b1;
            end
            PH_DEAD_B: if (deadCount == DEAD_CNT - 1'b1) begin
               phase <= PH_LOW;
            end else begin
               deadCount <= deadCount + 1'b1;
            end
         endcase
      end
   end

   assign lowOn   = (phase == PH_LOW);
   assign highOn  = (phase == PH_HIGH);
   assign lowRise = (phase == PH_DEAD_B) && enable
                    && (deadCount == DEAD_CNT - 1'b1);
endmodule // bms_bridge

/* File: bms_props.sv */
/* Port checker of the ballast mode sequencer.
   Assumes a bind into ballast_mode_sequencer, one clock. */
`timescale 1ns/100ps
module bms_props
   import bms_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       overTemp,
   input wire logic       highSideDrive,
   input wire logic       lowSideDrive,
   input wire logic       oscForceHigh,
   input wire logic       timerShortGnd,
   input wire logic       timerCharge1u,
   input wire logic       oscDischarge1u,
   input wire logic       oscDischarge15u,
   input wire logic       brightToTimer,
   input wire logic       floorAboveRamp,
   input wire logic       refPhase,
   input wire logic       faultLatched,
   input wire logic [2:0] modeState
);
   localparam int MIN_GAP = DEAD_CYC - 1;
   logic [CNT_W-1:0] idleCnt;
   logic             lowSeen;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ****
   // Helpers
   // ****
   always_ff @(posedge clk) begin
      if (!rst_n || highSideDrive || lowSideDrive) begin
         idleCnt <= '0;
      end else begin
         idleCnt <= idleCnt + 1'b1;
      end
   end
   // Cleared in lockout so each start must lead low
   always_ff @(posedge clk) begin
      if (!rst_n || modeState == 3'h0) begin
         lowSeen <= 1'b0;
      end else if (lowSideDrive) begin
         lowSeen <= 1'b1;
      end
   end
   // ****
   // Assertions
   // ****
   a_lockout_idle: assert property (
      modeState == 3'h0 && $stable(modeState) |-> !highSideDrive &&
      !lowSideDrive && oscForceHigh && timerShortGnd)
      else $error("lockout outputs wrong");
   a_drives_apart: assert property (
      !(highSideDrive && lowSideDrive)) else $error("drives overlap");
   a_dead_gap: assert property (
      $rose(highSideDrive) || $rose(lowSideDrive) |-> idleCnt >= MIN_GAP)
      else $error("dead time short");
   a_first_low: assert property (
      $rose(highSideDrive) |-> lowSeen) else $error("high side first");
   a_fault_off: assert property (
      faultLatched && $past(faultLatched) |-> !highSideDrive && !lowSideDrive)
      else $error("drive in fault");
   a_heat_latch: assert property (
      $rose(overTemp) |-> ##[1:4] faultLatched) else $error("no heat latch");
   a_warm_sources: assert property (
      modeState == 3'h1 && $stable(modeState) |-> timerCharge1u &&
      oscDischarge1u && !timerShortGnd) else $error("warm sources wrong");
   a_dim_sources: assert property (
      modeState == 3'h3 && $stable(modeState) |-> oscDischarge15u &&
      brightToTimer) else $error("dim sources wrong");
   a_ref_phase: assert property (
      modeState == 3'h3 |-> refPhase == $past(floorAboveRamp, 3))
      else $error("reference phase wrong");
endmodule // bms_props
bind ballast_mode_sequencer bms_props i_props (
   .clk, .rst_n, .overTemp, .highSideDrive, .lowSideDrive, .oscForceHigh,
   .timerShortGnd, .timerCharge1u, .oscDischarge1u, .oscDischarge15u,
   .brightToTimer, .floorAboveRamp, .refPhase, .faultLatched, .modeState
);

/* File: bms_tank.sv */
/* Behavioural half-bridge and lamp tank with oscillator ticks.
   Assumes drives from the sequencer; zero-cross delay set by the bench. */
`timescale 1ns/100ps
module bms_tank (
   input  wire logic       clk,
   input  wire logic       lowSideDrive,
   input  wire logic [9:0] zxDelay,
   output logic            halfPeriodEnd,
   output logic            zeroCross,
   output logic            floorAboveRamp
);
   localparam int HALF = 1200;
   int phaseCnt = 0;
   int zxCnt = 0;
   // Brightness stays inside 0.5V to 5V; not modelled further
   always_ff @(posedge clk) begin
      phaseCnt <= (phaseCnt >= HALF - 1) ? 0 : phaseCnt + 1;
      halfPeriodEnd <= (phaseCnt < 2);
   end
   // Load current crosses zero a set time into the low phase
   always_ff @(posedge clk) begin
      zxCnt <= lowSideDrive ? zxCnt + 1 : 0;
      zeroCross <= lowSideDrive && (zxCnt >= int'(zxDelay));
   end
   assign floorAboveRamp = lowSideDrive;
endmodule // bms_tank

/* File: testbench.sv */
/* Self-checking bench of the ballast mode sequencer.
   Assumes the tank model answers the drives. */
`timescale 1ns/100ps
module testbench
   import bms_pkg::*;
;
   typedef struct {
      logic [9:0] in;
      logic [2:0] mode;
      int         idx;
   } bms_row_t;
   logic       clk, rst_n, supplyAboveRise, supplyBelowFall, lineAboveOn;
   logic       lineBelowOff, shutdownInput, overTemp, timerAbove5v;
   logic       oscBelowMin, csAboveWarmupRef, csAboveLimit, zeroCross;
   logic       floorAboveRamp, halfPeriodEnd, highSideDrive, lowSideDrive;
   logic       oscForceHigh, timerShortGnd, timerCharge1u, oscDischarge1u;
   logic       oscCharge60u, oscDischarge15u, feedbackCharge, brightToTimer;
   logic       useFixedLimitRef, refPhase, faultLatched;
   logic [2:0] modeState;
   logic [9:0] zxDelay;
   int         error_cnt = 0;
   int         n_checks = 0;
   int         k, n, loLen, hiLen, pulses;
   wire logic [7:0] obs = {oscDischarge1u, timerShortGnd, oscForceHigh,
      faultLatched, brightToTimer, useFixedLimitRef, oscCharge60u,
      timerCharge1u};
   // Bits: supply up, down, line on, off, shutdown, heat, timer, osc,
   // warm-up current, limit; then mode and obs bit that must be high
   bms_row_t rows [14] = '{'{10'h280, 3'h1, 0}, '{10'h282, 3'h1, 1},
      '{10'h288, 3'h2, 2}, '{10'h28C, 3'h3, 3}, '{10'h28D, 3'h4, 4},
      '{10'h180, 3'h0, 6}, '{10'h240, 3'h0, 5}, '{10'h280, 3'h1, 0},
      '{10'h240, 3'h0, 6}, '{10'h288, 3'h2, 2}, '{10'h298, 3'h4, 4},
      '{10'h180, 3'h0, 6}, '{10'h288, 3'h2, 7}, '{10'h289, 3'h4, 4}};

   ballast_mode_sequencer i_dut (.clk, .rst_n, .supplyAboveRise,
      .supplyBelowFall, .lineAboveOn, .lineBelowOff, .shutdownInput,
      .overTemp, .timerAbove5v, .oscBelowMin, .csAboveWarmupRef,
      .csAboveLimit, .zeroCross, .floorAboveRamp, .halfPeriodEnd,
      .highSideDrive, .lowSideDrive, .oscForceHigh, .timerShortGnd,
      .timerCharge1u, .oscDischarge1u, .oscCharge60u, .oscDischarge15u,
      .feedbackCharge, .brightToTimer, .useFixedLimitRef, .refPhase,
      .faultLatched, .modeState);
   bms_tank i_tank (.clk, .lowSideDrive, .zxDelay, .halfPeriodEnd,
      .zeroCross, .floorAboveRamp);

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ****
   // Tasks
   // ****
   task automatic check(input string what, input logic [7:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("Checks %0d, errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic apply(input logic [9:0] v);
      {supplyAboveRise, supplyBelowFall, lineAboveOn, lineBelowOff,
         shutdownInput, overTemp, timerAbove5v, oscBelowMin,
         csAboveWarmupRef, csAboveLimit} = v;
   endtask
   // Bounded wait; a lapse is counted and ends the run
   task automatic wait_lvl(ref logic s, input logic v, output int c);
      for (c = 0; c < 5000 && s !== v; c++) @(negedge clk);
      if (s !== v) begin
         check("level wait", 8'(s), 8'(v));
         end_sim();
      end
   endtask
   task automatic wait_for(input logic [2:0] m);
      for (k = 0; k < 40 && modeState !== m; k++) @(negedge clk);
      if (modeState !== m) begin
         check("mode wait", 8'(modeState), 8'(m));
         end_sim();
      end
      repeat (6) @(negedge clk);
   endtask
   // ****
   // Sequence
   // ****
   initial begin
      rst_n = 1'b0;
      zxDelay = 10'h12C;
      apply(10'h000);
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      foreach (rows[i]) begin
         apply(rows[i].in);
         wait_for(rows[i].mode);
         check("mode", 8'(modeState), 8'(rows[i].mode));
         check("control", 8'(obs[rows[i].idx]), 8'h01);
      end
      // Shutdown toggle must clear the ignition fault
      apply(10'h2A8);
      repeat (10) @(negedge clk);
      apply(10'h280);
      wait_for(3'h1);
      check("fault after toggle", 8'(faultLatched), 8'h00);
      wait_lvl(lowSideDrive, 1'b1, n);
      check("high at first pulse", 8'(highSideDrive), 8'h00);
      wait_lvl(highSideDrive, 1'b1, n);
      wait_lvl(highSideDrive, 1'b0, hiLen);
      wait_lvl(lowSideDrive, 1'b1, n);
      check("dead time", 8'(n >= DEAD_CYC - 1), 8'h01);
      wait_lvl(lowSideDrive, 1'b0, loLen);
      check("duty", 8'(hiLen == loLen), 8'h01);
      apply(10'h28C);
      wait_for(3'h3);
      for (int j = 0; j < 2; j++) begin
         zxDelay = (j == 0) ? 10'h12C : 10'h014;
         pulses = 0;
         repeat (2500) @(negedge clk);
         wait_lvl(lowSideDrive, 1'b0, n);
         wait_lvl(lowSideDrive, 1'b1, n);
         repeat (6) @(negedge clk);
         check("ref phase", 8'(refPhase), 8'h01);
         check("dim sink", 8'(oscDischarge15u), 8'h01);
         repeat (6000) begin
            @(negedge clk);
            pulses += int'(feedbackCharge === 1'b1);
         end
         check("phase pulses", 8'(pulses > 0), 8'(j == 0));
      end
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      check("reset mode", 8'(modeState), 8'h00);
      check("reset pins", 8'({highSideDrive, lowSideDrive, oscForceHigh,
         timerShortGnd}), 8'h03);
      rst_n = 1'b1;
      end_sim();
   end
endmodule // testbench
